// *** verilog/operator_command_poll_unit.sv ***
// Polling executor between operator entry modules and the command computer.
// Assumes synchronous panel inputs, one 100 MHz clock, an APB master.
//
// Contract
// RULE_01: Relay module gives four function bits, one per switch, 1 when on.
// RULE_02: Only execute starts relay events; switches alone trigger nothing.
// RULE_03: Routine module forms 40 bits from ten BCD digits on execute.
// RULE_04: Any keyboard key press starts one five-bit word toward guidance.
// RULE_05: Tape mode feeds successive words; manual steps forward and reverse.
// RULE_06: Executor polls all entry modules in fixed order, repeating forever.
// RULE_07: A press interrupts the executor only when the scan reaches it.
// RULE_08: Data and address move to the computer only under its control.
// RULE_09: The attached module address only identifies the source module.
// RULE_10: Relay module data and address go as one 12-bit word.
// RULE_11: Routine or keyboard data and address go as four 12-bit words.
// RULE_12: On computer command, drive verification lamps on entry modules.
// RULE_13: On computer command after failure, show malfunction codes on panel.
// RULE_14: Computer sends each 24-bit message as two 12-bit words.
// RULE_15: Computer picks one of three converters by target equipment class.
// RULE_16: On good delivery computer orders verification on originating panel.
// RULE_17: Computer retries a preset count, then enters fault isolation.
// RULE_18: Finish a module's transfer before resuming scan at the next one.
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "poll_defines.svh"

module operator_command_poll_unit (
    input  wire logic                              i_core_clk,
    input  wire logic                              i_rst,
    input  wire logic                              i_psel,
    input  wire logic                              i_penable,
    input  wire logic                              i_pwrite,
    input  wire logic [`APB_AW-1:0]                i_paddr,
    input  wire logic [31:0]                       i_pwdata,
    output logic      [31:0]                       o_prdata,
    output logic                                   o_pready,
    output logic                                   o_pslverr,
    input  wire logic [`NUM_RELAY*`FUNC_W-1:0]     i_relay_func,
    input  wire logic [`NUM_RELAY-1:0]             i_relay_exec,
    input  wire logic [`NUM_ROUTINE*`DIGITS_W-1:0] i_routine_digits,
    input  wire logic [`NUM_ROUTINE-1:0]           i_routine_exec,
    input  wire logic                              i_key_press,
    input  wire logic [`KEY_W-1:0]                 i_key_code,
    input  wire logic                              i_tape_auto,
    input  wire logic                              i_tape_valid,
    input  wire logic [`KEY_W-1:0]                 i_tape_word,
    input  wire logic                              i_tape_step_fwd,
    input  wire logic                              i_tape_step_rev,
    output logic                                   o_tape_fwd,
    output logic                                   o_tape_rev,
    output logic      [`NUM_MOD-1:0]               o_verify_lamp,
    output logic      [7:0]                        o_maint_code,
    output logic                                   o_maint_show,
    output logic                                   o_irq
);

    // ======================================================================
    // Decoding helpers
    // Kind of the entry module sitting at a scan position.
    function automatic poll_pkg::kind_type kind_of(
        input logic [`POS_W-1:0] p);
        if (p < `POS_W'(`NUM_RELAY)) begin
            kind_of = poll_pkg::KIND_RELAY;
        end else if (p < `POS_W'(`NUM_RELAY + `NUM_ROUTINE)) begin
            kind_of = poll_pkg::KIND_ROUTINE;
        end else begin
            kind_of = poll_pkg::KIND_KEY;
        end
    endfunction

    // True when an APB address hits one of our registers.
    function automatic logic reg_mapped(input logic [`APB_AW-1:0] a);
        case (a)
            `REG_CTRL, `REG_STATUS, `REG_DATA, `REG_LAMP,
            `REG_MALF, `REG_IRQ_STAT, `REG_IRQ_MASK: reg_mapped = 1'b1;
            default: reg_mapped = 1'b0;
        endcase
    endfunction

    // Builds word number idx of a transfer; the address field carries only
    // the scan position so the computer can tell the source apart.
    function automatic poll_pkg::cmd_word_type build_word(
        input poll_pkg::kind_type       k,
        input logic [`WIDX_W-1:0]       idx,
        input logic [`POS_W-1:0]        p,
        input logic [`DIGITS_W-1:0]     s);
        logic [`ADDR_W-1:0] a;
        a = {1'b0, p};
        build_word.data = 12'h000;
        case (k)
            poll_pkg::KIND_RELAY: build_word.data = {a, 4'h0, s[3:0]};
            poll_pkg::KIND_ROUTINE: begin
                case (idx)
                    2'h0: build_word.data = {a, s[39:32]};
                    2'h1: build_word.data = s[31:20];
                    2'h2: build_word.data = s[19:8];
                    default: build_word.data = {s[7:0], 4'h0};
                endcase
            end
            default: begin
                if (idx == 2'h0) begin
                    build_word.data = {a, 3'h0, s[4:0]};
                end
            end
        endcase
    endfunction

    // ======================================================================
    // State
    poll_pkg::poll_state_type st_q;
    logic [`POS_W-1:0]    pos_q;
    logic [`NUM_MOD-1:0]  press;
    logic [`NUM_MOD-1:0]  pend_q;
    logic [6:0]           tick_cnt_q;
    logic                 tick;
    logic [`WIDX_W-1:0]   wcnt_q;
    logic [`WIDX_W-1:0]   rd_idx_q;
    logic [2:0]           nwords_q;
    logic [`DIGITS_W-1:0] snap_q;
    logic [`KEY_W-1:0]    key_q;
    logic                 tape_valid_q;
    logic [1:0]           ctrl_q;
    logic [`IRQ_W-1:0]    irq_stat_q;
    logic [`IRQ_W-1:0]    irq_mask_q;
    logic [`IRQ_W-1:0]    irq_set;
    logic                 ack_q;
    logic                 acc;
    logic                 wr_done;
    logic                 rd_done;
    logic                 hit;
    logic                 load_last;
    logic                 pop;
    logic                 done;
    logic                 tape_new;
    poll_pkg::kind_type   kind;
    poll_pkg::cmd_word_type wword;
    poll_pkg::cmd_word_type rword;

    assign kind     = kind_of(pos_q);
    assign tape_new = i_tape_auto & i_tape_valid & ~tape_valid_q;

    // ======================================================================
    // Entry module requests
    // A press is latched until the scan serves it; a new press in the
    // clearing cycle wins, so that request is not lost.
    genvar g;
    generate
        for (g = 0; g < `NUM_MOD; g++) begin : g_req
            if (g < `NUM_RELAY) begin : g_r
                assign press[g] = i_relay_exec[g];        // RULE_02
            end else if (g < `NUM_RELAY + `NUM_ROUTINE) begin : g_c
                assign press[g] = i_routine_exec[g - `NUM_RELAY]; // RULE_03
            end else begin : g_k
                assign press[g] = i_key_press | tape_new; // RULE_04
            end
            always_ff @(posedge i_core_clk) begin
                if (i_rst) begin
                    pend_q[g] <= 1'b0;
                end else if (press[g]) begin
                    pend_q[g] <= 1'b1;
                end else if (hit && pos_q == `POS_W'(g)) begin
                    pend_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Keyboard character latch: a key, or in tape mode the next tape word.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            key_q        <= 5'h00;
            tape_valid_q <= 1'b0;
        end else begin
            tape_valid_q <= i_tape_valid;
            if (i_key_press) begin
                key_q <= i_key_code;                      // RULE_04
            end else if (tape_new) begin
                key_q <= i_tape_word;                     // RULE_05
            end
        end
    end

    // ======================================================================
    // Scan timing and executor sequence
    // Dwell divider; it only runs while scanning so a transfer never
    // shortens the next module's dwell.
    always_ff @(posedge i_core_clk) begin
        if (i_rst || st_q != poll_pkg::ST_SCAN || !ctrl_q[`CTRL_SCAN_EN]) begin
            tick_cnt_q <= 7'h00;
        end else if (tick) begin
            tick_cnt_q <= 7'h00;
        end else begin
            tick_cnt_q <= tick_cnt_q + 7'h01;
        end
    end
    assign tick = (tick_cnt_q == 7'(`SCAN_DWELL_CYC - 1));

    // Service only happens with the computer's collect enable set; without
    // it the request stays pending and the scan moves past.
    assign hit = tick && st_q == poll_pkg::ST_SCAN && pend_q[pos_q]
               && ctrl_q[`CTRL_COLLECT_EN];               // RULE_07 RULE_08
    assign load_last = st_q == poll_pkg::ST_LOAD
                     && {1'b0, wcnt_q} == nwords_q - 3'h1;
    assign pop  = st_q == poll_pkg::ST_OFFER && rd_done
                && i_paddr == `REG_DATA;
    assign done = pop && {1'b0, rd_idx_q} == nwords_q - 3'h1;

    // Executor state, scan position and word counters.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            st_q     <= poll_pkg::ST_SCAN;
            pos_q    <= `POS_W'(0);
            wcnt_q   <= 2'h0;
            rd_idx_q <= 2'h0;
            nwords_q <= `WORDS_RELAY;
        end else begin
            case (st_q)
                poll_pkg::ST_SCAN: begin
                    if (hit) begin
                        st_q     <= poll_pkg::ST_LOAD;
                        wcnt_q   <= 2'h0;
                        nwords_q <= (kind == poll_pkg::KIND_RELAY)
                                  ? `WORDS_RELAY : `WORDS_LONG; // RULE_10 RULE_11
                    end else if (tick) begin
                        pos_q <= (pos_q == `POS_W'(`NUM_MOD - 1))
                               ? `POS_W'(0) : pos_q + `POS_W'(1); // RULE_06
                    end
                end
                poll_pkg::ST_LOAD: begin
                    wcnt_q <= wcnt_q + 2'h1;
                    if (load_last) begin
                        st_q     <= poll_pkg::ST_OFFER;
                        rd_idx_q <= 2'h0;
                    end
                end
                poll_pkg::ST_OFFER: begin
                    if (done) begin
                        st_q  <= poll_pkg::ST_SCAN;       // RULE_18
                        pos_q <= (pos_q == `POS_W'(`NUM_MOD - 1))
                               ? `POS_W'(0) : pos_q + `POS_W'(1);
                    end else if (pop) begin
                        rd_idx_q <= rd_idx_q + 2'h1;
                    end
                end
                default: st_q <= poll_pkg::ST_SCAN;
            endcase
        end
    end

    // Snapshot of the served module; switches are sampled only here, so
    // moving them between presses triggers nothing.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            snap_q <= 40'h0;
        end else if (hit) begin
            case (kind)
                poll_pkg::KIND_RELAY:
                    snap_q <= {36'h0, // RULE_01
                        i_relay_func[32'(pos_q) * `FUNC_W +: `FUNC_W]};
                poll_pkg::KIND_ROUTINE:
                    snap_q <= i_routine_digits[(32'(pos_q) - `NUM_RELAY)
                              * `DIGITS_W +: `DIGITS_W]; // RULE_03
                default: snap_q <= {35'h0, key_q};
            endcase
        end
    end

    // Word store for the transfer being offered.
    assign wword = build_word(kind, wcnt_q, pos_q, snap_q); // RULE_09
    cmd_word_store u_store (
        .i_core_clk (i_core_clk),
        .i_we       (st_q == poll_pkg::ST_LOAD),
        .i_waddr    (wcnt_q),
        .i_wdata    (wword),
        .i_raddr    (rd_idx_q),
        .o_rdata    (rword)
    );

    // ======================================================================
    // Tape reader steps
    // Manual steps pass through only outside tape mode; in tape mode the
    // reader advances once a keyboard transfer has been fully read.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_tape_fwd <= 1'b0;
            o_tape_rev <= 1'b0;
        end else begin
            o_tape_fwd <= (~i_tape_auto & i_tape_step_fwd)
                        | (i_tape_auto & done
                           & kind == poll_pkg::KIND_KEY); // RULE_05
            o_tape_rev <= ~i_tape_auto & i_tape_step_rev; // RULE_05
        end
    end

    // ======================================================================
    // APB slave
    // Every access takes one wait state so read data come from a register
    // and the word store has settled.
    assign acc       = i_psel & i_penable;
    assign o_pready  = acc & ack_q;
    assign o_pslverr = o_pready & ~reg_mapped(i_paddr);
    assign wr_done   = o_pready & i_pwrite & reg_mapped(i_paddr);
    assign rd_done   = o_pready & ~i_pwrite;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= acc & ~ack_q;
        end
    end

    // Read data captured in the first access cycle.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_prdata <= 32'h0;
        end else if (acc && !ack_q && !i_pwrite) begin
            case (i_paddr)
                `REG_CTRL:     o_prdata <= {30'h0, ctrl_q};
                `REG_STATUS:   o_prdata <= {13'h0, rd_idx_q, 1'b0, nwords_q,
                                            1'b0, pend_q, 1'b0, pos_q,
                                            st_q == poll_pkg::ST_OFFER};
                `REG_DATA:     o_prdata <= {20'h0, rword.data};
                `REG_LAMP:     o_prdata <= {25'h0, o_verify_lamp};
                `REG_MALF:     o_prdata <= {23'h0, o_maint_show, o_maint_code};
                `REG_IRQ_STAT: o_prdata <= {30'h0, irq_stat_q};
                `REG_IRQ_MASK: o_prdata <= {30'h0, irq_mask_q};
                default:       o_prdata <= 32'h0;
            endcase
        end
    end

    // Control, lamps and maintenance display, all written by the computer.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ctrl_q        <= `CTRL_RST;
            o_verify_lamp <= 7'h00;
            o_maint_code  <= 8'h00;
            o_maint_show  <= 1'b0;
            irq_mask_q    <= 2'h0;
        end else if (wr_done) begin
            case (i_paddr)
                `REG_CTRL:     ctrl_q <= i_pwdata[1:0];              // RULE_08
                `REG_LAMP:     o_verify_lamp <= i_pwdata[6:0];       // RULE_12
                `REG_MALF: begin
                    o_maint_code <= i_pwdata[7:0];                   // RULE_13
                    o_maint_show <= i_pwdata[`MALF_SHOW];            // RULE_13
                end
                `REG_IRQ_MASK: irq_mask_q <= i_pwdata[1:0];
                default: ;
            endcase
        end
    end

    // Sticky events, write one to clear; a new event beats the clear.
    assign irq_set = {done, load_last};
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            irq_stat_q <= 2'h0;
            o_irq      <= 1'b0;
        end else begin
            if (wr_done && i_paddr == `REG_IRQ_STAT) begin
                irq_stat_q <= (irq_stat_q & ~i_pwdata[1:0]) | irq_set;
            end else begin
                irq_stat_q <= irq_stat_q | irq_set;
            end
            o_irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ======================================================================
    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    sequence s_served;
        st_q == poll_pkg::ST_SCAN && hit;
    endsequence
    sequence s_loading;
        st_q == poll_pkg::ST_LOAD;
    endsequence

    chk_scan_order: assert property ( // RULE_06
        st_q == poll_pkg::ST_SCAN && tick && !hit && pos_q == 3'h6
        |=> pos_q == 3'h0)
        else $error("scan did not wrap to first module");
    chk_request_gate: assert property ( // RULE_07
        s_served |=> s_loading ##0 !pend_q[$past(pos_q)] || $past(press[pos_q]))
        else $error("served request not taken into load");
    chk_collect_ctl: assert property ( // RULE_08
        $rose(st_q == poll_pkg::ST_LOAD) |-> $past(ctrl_q[1]))
        else $error("transfer started without collect enable");
    chk_addr_field: assert property ( // RULE_09
        st_q == poll_pkg::ST_LOAD && wcnt_q == 2'h0
        |-> wword.data[11:8] == {1'b0, pos_q})
        else $error("first word lacks module address");
    chk_relay_single: assert property ( // RULE_10
        s_served ##0 kind == poll_pkg::KIND_RELAY
        |=> s_loading ##1 st_q == poll_pkg::ST_OFFER)
        else $error("relay transfer not one word");
    chk_four_words: assert property ( // RULE_11
        s_served ##0 kind != poll_pkg::KIND_RELAY
        |=> s_loading [*4] ##1 st_q == poll_pkg::ST_OFFER)
        else $error("long transfer not four words");
    chk_lamp_write: assert property ( // RULE_12
        wr_done && i_paddr == 8'h0c |=> o_verify_lamp == $past(i_pwdata[6:0]))
        else $error("verification lamps not updated");
    chk_maint_cause: assert property ( // RULE_13
        $rose(o_maint_show) |-> $past(wr_done && i_paddr == 8'h10))
        else $error("maintenance code shown without command");
    chk_resume_next: assert property ( // RULE_18
        done && pos_q != 3'h6 |=> st_q == poll_pkg::ST_SCAN
        && pos_q == $past(pos_q) + 3'h1)
        else $error("scan did not resume at next module");
    chk_irq_level: assert property (
        load_last && irq_mask_q[0] |=> ##1 o_irq)
        else $error("capture event did not raise interrupt");

endmodule

// *** verilog/poll_defines.svh ***
// Constants for the operator command poll unit: sizes, register map,
// field positions, reset values and timing counts.
// Assumes a 100 MHz core clock and a 32-bit APB slave port.
`ifndef POLL_DEFINES_SVH
`define POLL_DEFINES_SVH

// ==========================================================================
// Entry module population and word layout
`define NUM_RELAY       4
`define NUM_ROUTINE     2
`define NUM_MOD         7
`define POS_W           3
`define FUNC_W          4
`define DIGITS_W        40
`define KEY_W           5
`define WORD_W          12
`define ADDR_W          4
`define WIDX_W          2
`define WORDS_RELAY     3'h1
`define WORDS_LONG      3'h4

// ==========================================================================
// Timing
`define CLK_PERIOD_NS   10
`define SCAN_DWELL_NS   1000
`define SCAN_DWELL_CYC  ((`SCAN_DWELL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ==========================================================================
// Register map (byte addresses) and fields
`define APB_AW          8
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_DATA        8'h08
`define REG_LAMP        8'h0c
`define REG_MALF        8'h10
`define REG_IRQ_STAT    8'h14
`define REG_IRQ_MASK    8'h18
`define CTRL_SCAN_EN    0
`define CTRL_COLLECT_EN 1
`define CTRL_RST        2'h1
`define MALF_SHOW       8
`define IRQ_CAPTURE     0
`define IRQ_DONE        1
`define IRQ_W           2

`endif

// *** verilog/poll_pkg.sv ***
// Types shared by the operator command poll unit and its word store.
// Assumes poll_defines.svh is on the include path.
`include "poll_defines.svh"

package poll_pkg;

    // ======================================================================
    // Executor states and entry module kinds
    typedef enum logic [1:0] {ST_SCAN, ST_LOAD, ST_OFFER} poll_state_type;
    typedef enum logic [1:0] {KIND_RELAY, KIND_ROUTINE, KIND_KEY} kind_type;

    // ======================================================================
    // One parallel word handed to the command computer.
    typedef struct packed {
        logic [`WORD_W-1:0]  data;
    } cmd_word_type;

endpackage

// *** verilog/cmd_word_store.sv ***
// Small word store holding one transfer of up to four command words.
// Assumes a single clock; read data appear one edge after the address.
`timescale 1ns/1ps
`include "poll_defines.svh"

module cmd_word_store (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_we,
    input  wire logic [`WIDX_W-1:0]    i_waddr,
    input  wire poll_pkg::cmd_word_type i_wdata,
    input  wire logic [`WIDX_W-1:0]    i_raddr,
    output poll_pkg::cmd_word_type     o_rdata
);

    poll_pkg::cmd_word_type mem [0:(1<<`WIDX_W)-1];
    poll_pkg::cmd_word_type rdata_q;

    // Write port; contents need no reset since a word is always
    // written before the computer is offered it.
    always_ff @(posedge i_core_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    // Registered read port.
    always_ff @(posedge i_core_clk) begin
        rdata_q <= mem[i_raddr];
    end

    assign o_rdata = rdata_q;

endmodule

// *** sim/entry_panel.sv ***
// Behavioural model of the operator entry modules.
// Assumes the bench pulses i_go for one cycle per press.
`timescale 1ns/1ps
module entry_panel (
    input  wire logic        i_core_clk,
    input  wire logic        i_go,
    input  wire logic [1:0]  i_kind,
    input  wire logic [1:0]  i_idx,
    input  wire logic [39:0] i_val,
    output logic      [15:0] o_relay_func,
    output logic      [3:0]  o_relay_exec,
    output logic      [79:0] o_routine_digits,
    output logic      [1:0]  o_routine_exec,
    output logic             o_key_press,
    output logic      [4:0]  o_key_code
);
    // Switches rest off, so no input is unknown at time zero.
    initial begin
        {o_relay_func, o_relay_exec, o_routine_digits} = '0;
        {o_routine_exec, o_key_press, o_key_code} = '0;
    end
    // Settings persist after a press, as a real panel holds them.
    always @(posedge i_core_clk) begin
        o_relay_exec   <= 4'h0;
        o_routine_exec <= 2'h0;
        o_key_press    <= 1'b0;
        if (i_go && i_kind == 2'h0) begin
            o_relay_func[i_idx*4 +: 4] <= i_val[3:0];
            o_relay_exec[i_idx]        <= 1'b1;
        end
        if (i_go && i_kind == 2'h1) begin
            o_routine_digits[i_idx[0]*40 +: 40] <= i_val;
            o_routine_exec[i_idx[0]]            <= 1'b1;
        end
        if (i_go && i_kind == 2'h2) begin
            o_key_code  <= i_val[4:0];
            o_key_press <= 1'b1;
        end
    end
endmodule

// *** sim/operator_command_poll_unit_tb.sv ***
// Self-checking bench for the operator command poll unit.
// Assumes entry_panel as the panel model and APB access to the core.
`timescale 1ns/1ps
`include "poll_defines.svh"
module operator_command_poll_unit_tb;
    typedef struct packed {
        logic [1:0]  k;
        logic [1:0]  i;
        logic [39:0] v;
        logic [2:0]  n;
        logic [47:0] w;
    } row_type;
    // Each row: kind (3 for tape), index, value, word count, expected words.
    row_type rows [5] = '{
        '{2'h0, 2'h3, 40'hf, 3'h1, 48'h30f000000000},
        '{2'h1, 2'h1, 40'h1234567890, 3'h4, 48'h512345678900},
        '{2'h1, 2'h0, 40'h9876543210, 3'h4, 48'h498765432100},
        '{2'h2, 2'h0, 40'h11, 3'h4, 48'h611000000000},
        '{2'h3, 2'h0, 40'ha, 3'h4, 48'h60a000000000}};
    logic        core_clk, rst, psel, penable, pwrite, go, step_fwd, err;
    logic        pready, pslverr, key_press, tape_fwd, mshow, irq;
    logic        tape_auto, tape_valid, step_rev, tape_rev;
    logic [1:0]  kind, idx, routine_exec;
    logic [3:0]  relay_exec;
    logic [4:0]  key_code, tape_word;
    logic [6:0]  lamp;
    logic [7:0]  paddr, mcode;
    logic [15:0] relay_func;
    logic [31:0] pwdata, prdata, rd;
    logic [39:0] val;
    logic [79:0] digits;
    int          miscompares = 0, cmp_count = 0, cycles = 0;

    operator_command_poll_unit dut_u (
        .i_core_clk(core_clk), .i_rst(rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_relay_func(relay_func),
        .i_relay_exec(relay_exec), .i_routine_digits(digits),
        .i_routine_exec(routine_exec), .i_key_press(key_press),
        .i_key_code(key_code), .i_tape_auto(tape_auto),
        .i_tape_valid(tape_valid), .i_tape_word(tape_word),
        .i_tape_step_fwd(step_fwd), .i_tape_step_rev(step_rev),
        .o_tape_fwd(tape_fwd), .o_tape_rev(tape_rev),
        .o_verify_lamp(lamp), .o_maint_code(mcode),
        .o_maint_show(mshow), .o_irq(irq));
    entry_panel panel_u (
        .i_core_clk(core_clk), .i_go(go), .i_kind(kind), .i_idx(idx),
        .i_val(val), .o_relay_func(relay_func), .o_relay_exec(relay_exec),
        .o_routine_digits(digits), .o_routine_exec(routine_exec),
        .o_key_press(key_press), .o_key_code(key_code));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic end_sim();
        if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // A hang would otherwise stall the run; the ceiling is generous.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            $display("unexpected %0t got %h exp %h", $time, g, e);
            miscompares++;
        end
    endtask
    // Master holds the request until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic press(input int r);
        @(posedge core_clk);
        {go, kind, idx, val} <= {1'b1, rows[r].k, rows[r].i, rows[r].v};
        {tape_auto, tape_valid} <= {2{rows[r].k == 2'h3}};
        tape_word <= rows[r].v[4:0];
        @(posedge core_clk);
        go <= 1'b0;
    endtask

    initial begin
        {rst, psel, penable, pwrite, go, step_fwd, step_rev} = 7'h40;
        {paddr, pwdata, kind, idx, val, tape_word} = '0;
        {tape_auto, tape_valid} = 2'b00;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        chk({14'h0, irq, mshow, mcode, lamp, tape_fwd}, 32'h0);
        apb(1'b0, `REG_CTRL, 32'h0);
        chk(rd, 32'h1);
        press(0);
        repeat (800) @(posedge core_clk);
        apb(1'b0, `REG_STATUS, 32'h0);
        chk({31'h0, rd[0]}, 32'h0);
        apb(1'b1, `REG_IRQ_MASK, 32'h1);
        apb(1'b1, `REG_CTRL, 32'h3);
        for (int r = 0; r < 5; r++) begin
            press(r);
            rd = 32'h0;
            for (int t = 0; t < 300 && rd[0] !== 1'b1; t++)
                apb(1'b0, `REG_STATUS, 32'h0);
            repeat (2) @(posedge core_clk);
            chk({31'h0, irq}, 32'h1);
            for (int j = 0; j < rows[r].n; j++) begin
                apb(1'b0, `REG_DATA, 32'h0);
                chk(rd, {20'h0, rows[r].w[47-12*j -: 12]});
            end
            @(negedge core_clk);
            chk({31'h0, tape_fwd}, {31'h0, rows[r].k == 2'h3});
            apb(1'b0, `REG_IRQ_STAT, 32'h0);
            chk(rd, 32'h3);
            apb(1'b1, `REG_IRQ_STAT, 32'h3);
            repeat (2) @(posedge core_clk);
            chk({31'h0, irq}, 32'h0);
        end
        // The converter link lies beyond this block.
        apb(1'b1, `REG_LAMP, 32'h55);
        apb(1'b1, `REG_MALF, 32'h1a5);
        repeat (2) @(posedge core_clk);
        chk({16'h0, mshow, mcode, lamp}, 32'hd2d5);
        apb(1'b0, 8'h1c, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        {step_fwd, step_rev, tape_auto} <= 3'b110;
        @(posedge core_clk);
        {step_fwd, step_rev} <= 2'b00;
        @(negedge core_clk);
        chk({30'h0, tape_fwd, tape_rev}, 32'h3);
        end_sim();
    end
endmodule
